// File: rtl/msr_map.svh
`ifndef MSR_MAP_SVH
`define MSR_MAP_SVH

// Byte addresses of the 32-bit words; bit 1 picks the halfword in 16-bit mode.
`define MSR_FLAG_LO_ADDR 11'h428
`define MSR_FLAG_HI_ADDR 11'h42C
`define MSR_MASK_LO_ADDR 11'h440
`define MSR_MASK_HI_ADDR 11'h444
`define MSR_WORD_LSB 2
`define MSR_HALF_BIT 1
`define MSR_FLAGS_RESET 64'h0
`define MSR_MASK_RESET 64'h0
`define MSR_RUN_LENGTH 2'h3
`define MSR_RUN_FIRST 2'h1
`define MSR_ZERO_WORD 32'h0
`define MSR_ZERO_HALF 16'h0

`endif

// File: rtl/msr_pkg.sv
package msr_pkg;

  typedef struct packed {
    logic [10:0] addr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
  } msr_host_req_type;

  typedef struct packed {
    logic valid;
    logic [5:0] station_address;
    logic established;
  } msr_obs_type;

  typedef struct packed {
    logic start;
    logic [5:0] station_address;
  } msr_slot_type;

  typedef enum logic [1:0] {
    MSR_SEL_NONE,
    MSR_SEL_FLAG,
    MSR_SEL_MASK
  } msr_sel_type;

endpackage

// File: rtl/msr_member_status.sv
`timescale 1ns/1ps
`include "msr_map.svh"

// Operation
// - Three consecutive established observations set the station's member flag.
// - Three consecutive unestablished observations clear the station's member flag.
// - Flag bit n belongs to station address n, bits 0 through 63.
// - Outside hold, flags change only at the start of the own station time slot.
// - Start bit low and hold mode high keep every flag at zero.
// - Each group mask bit selects the flag bit at the same position.
// - In 16-bit mode the halfword addresses swap with endianness.
module msr_member_status #(
  parameter int STATIONS = 64
)
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire msr_pkg::msr_host_req_type host_req_i,
  input wire logic bus16_i,
  input wire logic big_endian_i,
  input wire msr_pkg::msr_obs_type obs_i,
  input wire msr_pkg::msr_slot_type slot_i,
  input wire logic [5:0] own_station_address_i,
  input wire logic sys_start_i,
  input wire logic member_hold_mode_i,
  output logic [31:0] host_rdata_o,
  output logic [STATIONS-1:0] member_flag_o,
  output logic [STATIONS-1:0] member_group_flags_o,
  output logic member_group_any_o
);
  import msr_pkg::*;

  // ==========================================================
  // Address decode
  // ==========================================================
  function automatic msr_sel_type word_sel(input logic [10:0] addr);
    logic [10:0] word_addr;
    begin
      word_addr = {addr[10:`MSR_WORD_LSB], 2'h0};
      if (word_addr == `MSR_FLAG_LO_ADDR || word_addr == `MSR_FLAG_HI_ADDR)
        word_sel = MSR_SEL_FLAG;
      else if (word_addr == `MSR_MASK_LO_ADDR || word_addr == `MSR_MASK_HI_ADDR)
        word_sel = MSR_SEL_MASK;
      else
        word_sel = MSR_SEL_NONE;
    end
  endfunction

  // Big-endian places bits 15..0 at the higher halfword address.
  function automatic logic low_half_sel(input logic [10:0] addr, input logic big);
    low_half_sel = (addr[`MSR_HALF_BIT] == big);
  endfunction

  function automatic logic upper_word(input logic [10:0] addr);
    upper_word = addr[`MSR_WORD_LSB];
  endfunction

  // ==========================================================
  // State
  // ==========================================================
  logic [STATIONS-1:0] member_flag_reg;
  logic [STATIONS-1:0] member_flag_next;
  logic [STATIONS-1:0] pending_reg;
  logic [STATIONS-1:0] pending_next;
  logic [STATIONS-1:0] run_level_reg;
  logic [STATIONS-1:0] run_level_next;
  logic [1:0] run_count_reg [STATIONS];
  logic [1:0] run_count_next [STATIONS];
  logic [STATIONS-1:0] member_group_mask_reg;
  logic [STATIONS-1:0] member_group_mask_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [STATIONS-1:0] group_flags_reg;
  logic [STATIONS-1:0] group_flags_next;
  logic group_any_reg;
  logic group_any_next;

  logic held;
  assign held = !sys_start_i && member_hold_mode_i;

  // ==========================================================
  // Membership tracking
  // ==========================================================
  always_comb
  begin
    logic hit;
    hit = 1'b0;
    pending_next = pending_reg;
    run_level_next = run_level_reg;
    run_count_next = run_count_reg;
    member_flag_next = member_flag_reg;
    for (int s = 0; s < STATIONS; s++)
    begin
      hit = obs_i.valid && (obs_i.station_address == 6'(s));
      if (hit)
      begin
        if (obs_i.established != run_level_reg[s])
        begin
          // A contradicting observation starts a fresh run of one.
          run_level_next[s] = obs_i.established;
          run_count_next[s] = `MSR_RUN_FIRST;
        end
        else if (run_count_reg[s] != `MSR_RUN_LENGTH)
        begin
          run_count_next[s] = run_count_reg[s] + 2'h1;
        end
        if (obs_i.established == run_level_reg[s] &&
            run_count_reg[s] + 2'h1 >= `MSR_RUN_LENGTH)
        begin
          pending_next[s] = obs_i.established;
        end
      end
    end
    if (slot_i.start && slot_i.station_address == own_station_address_i)
    begin
      member_flag_next = pending_next;
    end
    if (held)
    begin
      // Runs are dropped too, so release starts counting from scratch.
      member_flag_next = `MSR_FLAGS_RESET;
      pending_next = `MSR_FLAGS_RESET;
      run_level_next = `MSR_FLAGS_RESET;
      for (int s = 0; s < STATIONS; s++)
      begin
        run_count_next[s] = 2'h0;
      end
    end
  end

  // ==========================================================
  // Host access
  // ==========================================================
  always_comb
  begin
    logic [31:0] word;
    logic [31:0] merged;
    msr_sel_type sel;
    sel = word_sel(host_req_i.addr);
    word = `MSR_ZERO_WORD;
    merged = `MSR_ZERO_WORD;
    member_group_mask_next = member_group_mask_reg;
    rdata_next = rdata_reg;
    case (sel)
      MSR_SEL_FLAG:
      begin
        word = upper_word(host_req_i.addr) ? member_flag_reg[63:32] : member_flag_reg[31:0];
      end
      MSR_SEL_MASK:
      begin
        word = upper_word(host_req_i.addr) ? member_group_mask_reg[63:32]
                                           : member_group_mask_reg[31:0];
      end
      default:
      begin
        word = `MSR_ZERO_WORD;
      end
    endcase
    if (host_req_i.rd)
    begin
      if (!bus16_i)
        rdata_next = word;
      else if (low_half_sel(host_req_i.addr, big_endian_i))
        rdata_next = {`MSR_ZERO_HALF, word[15:0]};
      else
        rdata_next = {`MSR_ZERO_HALF, word[31:16]};
    end
    // The flag words are read-only; writes to them are dropped.
    if (host_req_i.wr && sel == MSR_SEL_MASK)
    begin
      if (!bus16_i)
        merged = host_req_i.wdata;
      else if (low_half_sel(host_req_i.addr, big_endian_i))
        merged = {word[31:16], host_req_i.wdata[15:0]};
      else
        merged = {host_req_i.wdata[15:0], word[15:0]};
      if (upper_word(host_req_i.addr))
        member_group_mask_next[63:32] = merged;
      else
        member_group_mask_next[31:0] = merged;
    end
    group_flags_next = member_flag_reg & member_group_mask_reg;
    group_any_next = |group_flags_next;
  end

  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      member_flag_reg <= `MSR_FLAGS_RESET;
      pending_reg <= `MSR_FLAGS_RESET;
      run_level_reg <= `MSR_FLAGS_RESET;
      for (int s = 0; s < STATIONS; s++)
      begin
        run_count_reg[s] <= 2'h0;
      end
      member_group_mask_reg <= `MSR_MASK_RESET;
      rdata_reg <= `MSR_ZERO_WORD;
      group_flags_reg <= `MSR_FLAGS_RESET;
      group_any_reg <= 1'b0;
    end
    else
    begin
      member_flag_reg <= member_flag_next;
      pending_reg <= pending_next;
      run_level_reg <= run_level_next;
      run_count_reg <= run_count_next;
      member_group_mask_reg <= member_group_mask_next;
      rdata_reg <= rdata_next;
      group_flags_reg <= group_flags_next;
      group_any_reg <= group_any_next;
    end
  end

  assign host_rdata_o = rdata_reg;
  assign member_flag_o = member_flag_reg;
  assign member_group_flags_o = group_flags_reg;
  assign member_group_any_o = group_any_reg;

endmodule

// File: verif/msr_member_status_monitor.sv
`timescale 1ns/1ps
`include "msr_map.svh"
// ==========
// Port checker
module msr_member_status_monitor #(
  parameter int STATIONS = 64
)
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire msr_pkg::msr_host_req_type host_req_i,
  input wire logic bus16_i,
  input wire logic big_endian_i,
  input wire msr_pkg::msr_obs_type obs_i,
  input wire msr_pkg::msr_slot_type slot_i,
  input wire logic [5:0] own_station_address_i,
  input wire logic sys_start_i,
  input wire logic member_hold_mode_i,
  input wire logic [31:0] host_rdata_o,
  input wire logic [STATIONS-1:0] member_flag_o,
  input wire logic [STATIONS-1:0] member_group_flags_o,
  input wire logic member_group_any_o
);
  import msr_pkg::*;
  wire logic run_ok = sys_start_i || !member_hold_mode_i;
  wire logic own_slot = slot_i.start && slot_i.station_address == own_station_address_i;
  wire logic slot_ok = own_slot && !obs_i.valid && run_ok;
  wire logic rd32 = host_req_i.rd && !bus16_i;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  // A run is only judged when every observation names the same station.
  sequence obs_is(e);
    obs_i.valid && obs_i.established == e && run_ok;
  endsequence
  sequence obs_same(e);
    obs_i.valid && obs_i.established == e && run_ok && $stable(obs_i.station_address);
  endsequence
  property p_run(e);
    obs_is(e) ##1 obs_same(e) [*2] ##1 slot_ok
      |=> member_flag_o[$past(obs_i.station_address, 2)] == e;
  endproperty
  run_set_a: assert property (p_run(1)) else $error("flag not set");
  run_clear_a: assert property (p_run(0)) else $error("flag not cleared");
  run_restart_a: assert property (
    obs_is(1) ##1 obs_same(1) [*2] ##1 obs_same(0) [*2] ##1 obs_same(1) ##1 obs_same(0)
      ##1 slot_ok |=> member_flag_o[$past(obs_i.station_address, 2)]) else $error("run");
  flag_stable_a: assert property (!own_slot && run_ok |=> $stable(member_flag_o))
    else $error("flag moved");
  hold_zero_a: assert property (!run_ok |=> member_flag_o == '0)
    else $error("hold");
  group_sub_a: assert property (1 |=> (member_group_flags_o & ~$past(member_flag_o)) == '0)
    else $error("group");
  group_any_a: assert property (member_group_any_o == |member_group_flags_o)
    else $error("any");
  flag_read_a: assert property (rd32 && host_req_i.addr == `MSR_FLAG_HI_ADDR
    |=> host_rdata_o == $past(member_flag_o[63:32])) else $error("flag read");
  half_swap_a: assert property (host_req_i.rd && bus16_i
    && host_req_i.addr == (big_endian_i ? 11'h42C : 11'h42E)
    |=> host_rdata_o == {16'h0, $past(member_flag_o[63:48])}) else $error("half");
  set_c: cover property (p_run(1));
  clear_c: cover property (p_run(0));
  hold_c: cover property (!run_ok);
endmodule
bind msr_member_status msr_member_status_monitor #(.STATIONS(STATIONS)) u_mon (.clk_sys_i,
  .reset_i, .host_req_i, .bus16_i, .big_endian_i, .obs_i, .slot_i, .own_station_address_i,
  .sys_start_i, .member_hold_mode_i, .host_rdata_o, .member_flag_o, .member_group_flags_o,
  .member_group_any_o);

// File: verif/tb.sv
`timescale 1ns/1ps
`include "msr_map.svh"
module tb;
  import msr_pkg::*;
  logic clk_sys_i = 0;
  logic reset_i = 1;
  msr_host_req_type req = '0;
  msr_obs_type obs = '0;
  msr_slot_type slot = '0;
  logic bus16 = 0;
  logic big = 0;
  logic sys_start = 1;
  logic hold = 0;
  logic [5:0] own = 6'h07;
  logic [31:0] rdata;
  logic [63:0] flag;
  logic [63:0] gflag;
  logic gany;
  int fails = 0;
  int n_compared = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  msr_member_status u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .host_req_i(req),
    .bus16_i(bus16), .big_endian_i(big), .obs_i(obs), .slot_i(slot),
    .own_station_address_i(own), .sys_start_i(sys_start), .member_hold_mode_i(hold),
    .host_rdata_o(rdata), .member_flag_o(flag), .member_group_flags_o(gflag),
    .member_group_any_o(gany));
  // ==========
  // Access tasks
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(logic [63:0] got, logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Each access ends with an idle cycle so no strobe is driven twice in one step.
  task automatic wr(logic [10:0] a, logic [31:0] d);
    req = '{a, 1'b0, 1'b1, d};
    tick();
    req = '0;
    tick();
  endtask
  task automatic rd(logic [10:0] a, logic [31:0] exp);
    req = '{a, 1'b1, 1'b0, 32'h0};
    tick();
    req = '0;
    tick();
    chk(64'(rdata), 64'(exp));
  endtask
  // Observations in back-to-back cycles, bit 0 of p first, then a slot start.
  task automatic run(logic [5:0] s, logic [7:0] p, int n, logic [5:0] at);
    for (int i = 0; i < n; i++)
    begin
      obs = '{1'b1, s, p[i]};
      tick();
    end
    obs = '0;
    slot = '{1'b1, at};
    tick();
    slot = '0;
    tick(3);
  endtask
  task automatic stop_test();
    if (fails == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========
  // Sequence
  initial
  begin
    tick(20);
    reset_i = 0;
    tick();
    rd(`MSR_MASK_LO_ADDR, 32'h0);
    rd(`MSR_MASK_HI_ADDR, 32'h0);
    wr(`MSR_FLAG_LO_ADDR, 32'hFFFFFFFF);
    rd(`MSR_FLAG_LO_ADDR, 32'h0);
    rd(11'h7FC, 32'h0);
    wr(`MSR_MASK_LO_ADDR, 32'h20);
    wr(`MSR_MASK_HI_ADDR, 32'h80000000);
    rd(`MSR_MASK_HI_ADDR, 32'h80000000);
    run(6'd5, 8'h07, 3, 6'd9);
    chk(flag, 64'h0);
    run(6'd5, 8'h07, 3, 6'd7);
    chk(flag, 64'h20);
    chk(64'(gany), 64'h1);
    run(6'd63, 8'h07, 3, 6'd7);
    rd(`MSR_FLAG_HI_ADDR, 32'h80000000);
    run(6'd5, 8'h27, 7, 6'd7);
    chk(flag, 64'h8000000000000020);
    run(6'd5, 8'h00, 3, 6'd7);
    chk(gflag, 64'h8000000000000000);
    bus16 = 1;
    big = 1;
    rd(11'h42C, 32'h8000);
    wr(`MSR_MASK_LO_ADDR, 32'hABCD);
    big = 0;
    wr(`MSR_MASK_LO_ADDR, 32'h1234);
    rd(11'h42E, 32'h8000);
    bus16 = 0;
    rd(`MSR_MASK_LO_ADDR, 32'hABCD1234);
    sys_start = 0;
    hold = 1;
    tick(2);
    chk(flag, 64'h0);
    chk(64'(gany), 64'h0);
    hold = 0;
    run(6'd5, 8'h07, 3, 6'd7);
    chk(flag, 64'h20);
    // A new own address must move the update point with it.
    own = 6'h09;
    run(6'd5, 8'h00, 3, 6'd9);
    chk(flag, 64'h0);
    stop_test();
  end
endmodule
